/* File: src/sbrg_top.sv */
// Purpose: baud rate generator with AHB-Lite registers and receive/transmit interrupt flags
// Assumes: event and status inputs come from shifter logic on i_clk
// Notes: reads take one wait state, writes none; response always OKAY
// Operation
// - High divisor byte is its own writable 8-bit register, reset zero.
// - High byte left out of the divisor unless wide generator selected; else low byte alone.
// - Writing the high divisor byte restarts the rate counter.
// - Async, narrow, low speed: rate is clock over 64 times divisor plus one.
// - Async, wide, low speed: rate is clock over 16 times divisor plus one.
// - Sync mode: clock over 4 times divisor plus one; speed select ignored.
// - Wide divisor is high and low bytes joined as one value.
// - Receive flag at bit 5, transmit flag at bit 4 of flag register.
// - Receive and transmit enables at bits 5 and 4 of enable register.
`timescale 1ns/1ps
`include "sbrg_regs.svh"
module sbrg_top #(
  parameter int DIV_W = 16,
  parameter int PRESC_W = 6
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_rx_event,
  input wire logic i_tx_event,
  input wire logic i_tx_shift_empty,
  output logic o_rate_tick,
  output logic o_port_enable,
  output logic o_sync_mode,
  output logic o_clk_master,
  output logic o_clk_polarity,
  output logic o_irq,
  input wire sbrg_pkg::sbrg_factor_type i_unused_factor
);
  import sbrg_pkg::*;

  generate
    if (DIV_W != 16) begin : g_bad_div
      $error("sbrg_top divisor must be 16 bits, two bytes");
    end
    if (PRESC_W < 6) begin : g_bad_presc
      $error("sbrg_top prescaler must hold a count of 63");
    end
    if (((`SBRG_FACTOR_SLOW - 1) >> PRESC_W) != 0) begin : g_bad_fit
      $error("sbrg_top prescaler too narrow for the slowest factor");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic accept;
  logic dph_wr_q;
  logic dph_rd_q;
  logic rd_done_q;
  logic [`SBRG_ADDR_W-1:0] addr_q;
  logic wr_en;
  logic rd_load;
  logic [31:0] hrdata_q;
  logic [7:0] rd_byte;
  logic [DIV_W-1:0] rd_count;
  logic unused_ok;

  assign accept = i_hsel && i_htrans[1] && i_hready;
  // Read data come from a flop, so reads stall one cycle to load it
  assign o_hreadyout = !(dph_rd_q && !rd_done_q);
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;
  assign wr_en = dph_wr_q;
  assign rd_load = dph_rd_q && !rd_done_q;
  // Size is not checked; every access is treated as a whole word
  assign unused_ok = &{1'b0, i_hsize, i_unused_factor, i_haddr[31:`SBRG_ADDR_W], i_haddr[1:0]};

  // Data phase state only moves while the bus is ready
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dph_wr_q <= 1'b0;
      dph_rd_q <= 1'b0;
      addr_q <= '0;
    end else if (i_hready) begin
      dph_wr_q <= accept && i_hwrite;
      dph_rd_q <= accept && !i_hwrite;
      addr_q <= {i_haddr[`SBRG_ADDR_W-1:2], 2'b00};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= dph_rd_q && !o_hreadyout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [7:0] baud_ctrl_q;
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] irq_flags_q;
  logic [7:0] irq_flags_d;
  logic [7:0] irq_en_q;
  logic [7:0] irq_clear;
  logic wr_low;
  logic wr_high;

  assign wr_low = wr_en && (addr_q == `SBRG_OFS_DIV_LOW);
  assign wr_high = wr_en && (addr_q == `SBRG_OFS_DIV_HIGH);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_low_q <= `SBRG_RST_BYTE;
    end else if (wr_low) begin
      div_low_q <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_high_q <= `SBRG_RST_BYTE;
    end else if (wr_high) begin
      div_high_q <= i_hwdata[7:0];
    end
  end

  // Control registers keep only their implemented bits; the rest read zero, except transmit control bit 1, which reads the shifter empty input
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      baud_ctrl_q <= `SBRG_RST_BYTE;
    end else if (wr_en && (addr_q == `SBRG_OFS_BAUD_CTRL)) begin
      baud_ctrl_q <= i_hwdata[7:0] & `SBRG_BAUD_CTRL_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_ctrl_q <= `SBRG_RST_BYTE;
    end else if (wr_en && (addr_q == `SBRG_OFS_TX_CTRL)) begin
      tx_ctrl_q <= i_hwdata[7:0] & `SBRG_TX_CTRL_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_ctrl_q <= `SBRG_RST_BYTE;
    end else if (wr_en && (addr_q == `SBRG_OFS_RX_CTRL)) begin
      rx_ctrl_q <= i_hwdata[7:0] & `SBRG_RX_CTRL_MASK;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= `SBRG_RST_BYTE;
    end else if (wr_en && (addr_q == `SBRG_OFS_IRQ_ENABLES)) begin
      irq_en_q <= i_hwdata[7:0] & `SBRG_IRQ_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags
  always_comb begin
    irq_clear = 8'h00;
    if (wr_en && (addr_q == `SBRG_OFS_IRQ_CLEAR)) begin
      irq_clear = i_hwdata[7:0];
    end
    // A new event wins over a clear in the same cycle
    irq_flags_d = irq_flags_q & ~irq_clear;
    irq_flags_d[`SBRG_BIT_RX_FLAG] = irq_flags_d[`SBRG_BIT_RX_FLAG] | i_rx_event;
    irq_flags_d[`SBRG_BIT_TX_FLAG] = irq_flags_d[`SBRG_BIT_TX_FLAG] | i_tx_event;
  end

  // Flags latch whether enabled or not, until software clears them
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_flags_q <= `SBRG_RST_BYTE;
    end else begin
      irq_flags_q <= irq_flags_d;
    end
  end

  // Level output; drops in the cycle after the clear or disable write
  assign o_irq = |(irq_flags_q & irq_en_q & `SBRG_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode and divisor
  logic wide_generator_select;
  logic high_speed_select;
  logic sync_mode;
  logic port_enable;
  sbrg_factor_type factor;
  logic [PRESC_W-1:0] presc_load;
  logic [DIV_W-1:0] divisor;
  logic [3:0] mode_q;
  logic mode_change;
  logic restart;

  assign wide_generator_select = baud_ctrl_q[`SBRG_BIT_WIDE_GEN];
  assign high_speed_select = tx_ctrl_q[`SBRG_BIT_HIGH_SPEED];
  assign sync_mode = tx_ctrl_q[`SBRG_BIT_SYNC_MODE];
  assign port_enable = rx_ctrl_q[`SBRG_BIT_PORT_ENABLE];

  // Narrow mode keeps the high byte out entirely
  assign divisor = wide_generator_select ? {div_high_q, div_low_q} : {8'h00, div_low_q};

  always_comb begin
    factor = SBRG_DIV_SLOW;
    if (sync_mode) begin
      factor = SBRG_DIV_FAST;
    end else if (wide_generator_select && high_speed_select) begin
      factor = SBRG_DIV_FAST;
    end else if (wide_generator_select || high_speed_select) begin
      factor = SBRG_DIV_MID;
    end else begin
      factor = SBRG_DIV_SLOW;
    end
  end

  always_comb begin
    case (factor)
      SBRG_DIV_SLOW: presc_load = PRESC_W'(`SBRG_FACTOR_SLOW - 1);
      SBRG_DIV_MID: presc_load = PRESC_W'(`SBRG_FACTOR_MID - 1);
      SBRG_DIV_FAST: presc_load = PRESC_W'(`SBRG_FACTOR_FAST - 1);
      default: presc_load = PRESC_W'(`SBRG_FACTOR_SLOW - 1);
    endcase
  end

  // A mode change alters the period, so a stale count is dropped
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 4'h0;
    end else begin
      mode_q <= {port_enable, sync_mode, wide_generator_select, high_speed_select};
    end
  end

  assign mode_change = mode_q != {port_enable, sync_mode, wide_generator_select, high_speed_select};
  assign restart = wr_high || wr_low || mode_change || !port_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Rate counters
  logic presc_expire;
  logic div_expire;
  logic tick_q;

  // Prescaler runs every clock; its period is the mode's divide factor
  sbrg_counter #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(restart),
    .i_step(1'b1),
    .i_load_val(presc_load),
    .o_expire(presc_expire),
    .o_count()
  );

  // Reloads from the divisor each time it runs out
  sbrg_counter #(
    .WIDTH(DIV_W)
  ) u_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_restart(restart),
    .i_step(presc_expire),
    .i_load_val(divisor),
    .o_expire(div_expire),
    .o_count(rd_count)
  );

  // Registered tick costs one cycle of lag but never glitches
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_expire && port_enable;
    end
  end

  assign o_rate_tick = tick_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control outputs
  // Copies lag the control bits by one cycle; users see settled levels
  logic [3:0] ctrl_out_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_out_q <= 4'h0;
    end else begin
      ctrl_out_q <= {port_enable, sync_mode, tx_ctrl_q[`SBRG_BIT_CLK_SRC] && sync_mode,
        baud_ctrl_q[`SBRG_BIT_CLK_POL]};
    end
  end

  assign o_port_enable = ctrl_out_q[3];
  assign o_sync_mode = ctrl_out_q[2];
  assign o_clk_master = ctrl_out_q[1];
  assign o_clk_polarity = ctrl_out_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    case (addr_q)
      `SBRG_OFS_DIV_LOW: rd_byte = div_low_q;
      `SBRG_OFS_DIV_HIGH: rd_byte = div_high_q;
      `SBRG_OFS_BAUD_CTRL: rd_byte = baud_ctrl_q;
      `SBRG_OFS_TX_CTRL: begin
        rd_byte = tx_ctrl_q;
        rd_byte[`SBRG_BIT_SHIFT_EMPTY] = i_tx_shift_empty;
      end
      `SBRG_OFS_RX_CTRL: rd_byte = rx_ctrl_q;
      `SBRG_OFS_IRQ_FLAGS: rd_byte = irq_flags_q;
      `SBRG_OFS_IRQ_ENABLES: rd_byte = irq_en_q;
      // Clear register is write-only
      `SBRG_OFS_IRQ_CLEAR: rd_byte = 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_load) begin
      // Counter value is taken in the first data cycle of the read
      if (addr_q == `SBRG_OFS_COUNT) begin
        hrdata_q <= {16'h0000, rd_count};
      end else begin
        hrdata_q <= {24'h00_0000, rd_byte} | {31'h0, unused_ok};
      end
    end
  end
endmodule

/* File: src/sbrg_regs.svh */
// Purpose: register map, field positions, reset values and divide factors
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: byte offsets, narrow registers sit in the low bits
`ifndef SBRG_REGS_SVH
`define SBRG_REGS_SVH

`define SBRG_ADDR_W 8
`define SBRG_OFS_DIV_LOW 8'h00
`define SBRG_OFS_DIV_HIGH 8'h04
`define SBRG_OFS_BAUD_CTRL 8'h08
`define SBRG_OFS_TX_CTRL 8'h0c
`define SBRG_OFS_RX_CTRL 8'h10
`define SBRG_OFS_IRQ_FLAGS 8'h14
`define SBRG_OFS_IRQ_ENABLES 8'h18
`define SBRG_OFS_IRQ_CLEAR 8'h1c
`define SBRG_OFS_COUNT 8'h20

`define SBRG_BIT_WIDE_GEN 3
`define SBRG_BIT_CLK_POL 4
`define SBRG_BIT_CLK_SRC 7
`define SBRG_BIT_TX_ENABLE 5
`define SBRG_BIT_SYNC_MODE 4
`define SBRG_BIT_HIGH_SPEED 2
`define SBRG_BIT_SHIFT_EMPTY 1
`define SBRG_BIT_PORT_ENABLE 7
`define SBRG_BIT_CONT_RX 4
`define SBRG_BIT_RX_FLAG 5
`define SBRG_BIT_TX_FLAG 4

`define SBRG_RST_BYTE 8'h00
`define SBRG_BAUD_CTRL_MASK 8'h18
`define SBRG_TX_CTRL_MASK 8'hfd
`define SBRG_RX_CTRL_MASK 8'hf8
`define SBRG_IRQ_MASK 8'h30

`define SBRG_FACTOR_SLOW 64
`define SBRG_FACTOR_MID 16
`define SBRG_FACTOR_FAST 4

`endif

/* File: src/sbrg_pkg.sv */
// Purpose: shared types of the baud rate generator
// Assumes: nothing beyond the register header
// Notes: prescale factor selection is an enum
package sbrg_pkg;
  typedef enum logic [1:0] {
    SBRG_DIV_SLOW,
    SBRG_DIV_MID,
    SBRG_DIV_FAST
  } sbrg_factor_type;
endpackage

/* File: src/sbrg_counter.sv */
// Purpose: reloadable down counter with one-cycle expire pulse
// Assumes: i_load_val stable while counting, or a restart follows a change
// Notes: expires every i_load_val+1 enabled cycles
`timescale 1ns/1ps
module sbrg_counter #(
  parameter int WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_step,
  input wire logic [WIDTH-1:0] i_load_val,
  output logic o_expire,
  output logic [WIDTH-1:0] o_count
);
  logic [WIDTH-1:0] count_q;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("sbrg_counter needs WIDTH of at least 1");
    end
  endgenerate

  assign o_expire = i_step && (count_q == '0) && !i_restart;
  assign o_count = count_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
    end else if (i_restart) begin
      count_q <= i_load_val;
    end else if (i_step) begin
      if (count_q == '0) begin
        count_q <= i_load_val;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

/* File: test/sbrg_props.sv */
// Purpose: bus, tick and irq properties of sbrg_top
// Assumes: one slave, hready fed back from hreadyout
// Notes: data phase tracked in helper flops
`timescale 1ns/1ps
`include "sbrg_regs.svh"
module sbrg_props (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_rx_event,
  input wire logic i_tx_event,
  input wire logic o_rate_tick,
  input wire logic o_port_enable,
  input wire logic o_irq
);
  logic dp_q;
  logic dw_q;
  logic [7:0] da_q;
  wire logic take = i_hsel & i_htrans[1] & i_hready;
  wire logic wr = dp_q & dw_q & i_hready;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dp_q <= 1'b0;
      dw_q <= 1'b0;
      da_q <= 8'h00;
    end else if (i_hready) begin
      dp_q <= take;
      dw_q <= i_hwrite;
      da_q <= i_haddr[7:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_resp_okay: assert property (o_hresp == 1'b0) else $error("hresp not okay");
  a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout) else $error("write stalled");
  a_read_wait: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
  a_tick_spaced: assert property (o_rate_tick |=> !o_rate_tick [*3]) else $error("tick gap under 4");
  a_tick_enable: assert property (!o_port_enable [*3] |-> !o_rate_tick) else $error("tick while off");
  // Restart pushes the next tick at least five cycles out
  a_restart_quiet: assert property (wr && da_q == `SBRG_OFS_DIV_HIGH |=> ##1 !o_rate_tick [*3])
    else $error("tick soon after restart");
  a_irq_cause: assert property ($rose(o_irq) |-> $past(i_rx_event | i_tx_event | wr))
    else $error("irq rose without cause");
  a_irq_off: assert property (wr && da_q == `SBRG_OFS_IRQ_ENABLES && i_hwdata[5:4] == 2'b00 |=> !o_irq)
    else $error("irq kept after disable");
  a_irq_clear: assert property (wr && da_q == `SBRG_OFS_IRQ_CLEAR && i_hwdata[5:4] == 2'b11
    && !(i_rx_event | i_tx_event) |=> !o_irq) else $error("irq kept after clear");
  c_tick: cover property (o_rate_tick);
  c_irq: cover property ($rose(o_irq));
  c_restart: cover property (wr && da_q == `SBRG_OFS_DIV_HIGH);
endmodule

/* File: test/sbrg_remote.sv */
// Purpose: remote port sharing the bit rate
// Assumes: one frame per arm pulse
// Notes: rx event at frame end, tx event one cycle later
`timescale 1ns/1ps
module sbrg_remote #(
  parameter int FRAME = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_arm,
  output logic o_rx_event,
  output logic o_tx_event,
  output logic o_shift_empty
);
  logic [3:0] bits_q;
  logic busy_q;
  wire logic last = busy_q & i_tick & (bits_q == 4'(FRAME - 1));
  assign o_shift_empty = !busy_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bits_q <= 4'h0;
      busy_q <= 1'b0;
      o_rx_event <= 1'b0;
      o_tx_event <= 1'b0;
    end else begin
      o_rx_event <= last;
      o_tx_event <= o_rx_event;
      if (!busy_q) begin
        busy_q <= i_arm;
      end else if (i_tick) begin
        bits_q <= last ? 4'h0 : bits_q + 4'h1;
        busy_q <= !last;
      end
    end
  end
endmodule

/* File: test/serial_baud_rate_generator_tb.sv */
// Purpose: self-checking bench for sbrg_top
// Assumes: one AHB-Lite slave, hready fed back
// Notes: rates measured tick to tick
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
  import sbrg_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0, arm = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h4015;
  logic [1:0] htrans = 2'b00;
  logic hready, tick, rxe, txe, empty, irq, pe, sm, cm, cp;
  logic [2:0] modes [7] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
  int errors = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  sbrg_top u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(), .o_hrdata(hrdata), .i_rx_event(rxe), .i_tx_event(txe), .i_tx_shift_empty(empty),
    .o_rate_tick(tick), .o_port_enable(pe), .o_sync_mode(sm), .o_clk_master(cm), .o_clk_polarity(cp),
    .o_irq(irq), .i_unused_factor(SBRG_DIV_SLOW));
  sbrg_remote u_remote (.i_clk(clk), .i_rst_n(rst_n), .i_tick(tick), .i_arm(arm), .o_rx_event(rxe),
    .o_tx_event(txe), .o_shift_empty(empty));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Mode bits are sync, wide, high speed
  function automatic int per(logic [2:0] m, logic [7:0] hi, logic [7:0] lo);
    int n = m[1] ? {hi, lo} : lo;
    int f = m[2] ? 4 : (m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64));
    return f * (n + 1);
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask
  task automatic gap(output int c);
    c = 0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      c++;
    end while (tick !== 1'b1);
  endtask
  task automatic frame();
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    do @(posedge clk); while (txe !== 1'b1);
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      $display("ERROR t=%0t timeout cycles %h limit %h", $time, cyc, 90000);
      wrap_up();
    end
  end
  initial begin
    logic [31:0] r;
    logic [7:0] lo, hi;
    int c;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Idle remote shows an empty shifter in bit 1
    for (int a = 0; a <= 36; a += 4) rd(a[7:0], (a == 12) ? 32'h2 : 32'h0);
    repeat (4) begin
      r = xs();
      wr(8'h04, r);
      rd(8'h04, {24'h0, r[7:0]});
    end
    wr(8'h24, xs());
    rd(8'h24, 32'h0);
    foreach (modes[i]) begin
      r = xs();
      lo = {4'h0, r[3:0]};
      hi = modes[i][1] ? 8'h01 : (r[15:8] | 8'h01);
      wr(8'h00, {24'h0, lo});
      wr(8'h04, {24'h0, hi});
      wr(8'h08, {27'h0, r[17], modes[i][1], 3'h0});
      wr(8'h0c, {24'h0, r[16], 2'b00, modes[i][2], 1'b0, modes[i][0], 2'h0});
      wr(8'h10, 32'h80);
      gap(c);
      chk(32'(c), 32'(per(modes[i], hi, lo)));
      chk({28'h0, pe, sm, cm, cp}, {28'h0, 1'b1, modes[i][2], r[16] & modes[i][2], r[17]});
    end
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h7);
    gap(c);
    repeat (100) @(posedge clk);
    wr(8'h04, 32'h0);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (tick !== 1'b1);
    chk(32'(c), 32'(per(3'b000, 8'h00, 8'h07) + 1));
    wr(8'h0c, 32'h10);
    rd(8'h14, 32'h0);
    frame();
    rd(8'h14, 32'h30);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h18, 32'hff);
    rd(8'h18, 32'h30);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1c, 32'h20);
    rd(8'h14, 32'h10);
    wr(8'h18, 32'h20);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h1c, 32'h10);
    rd(8'h14, 32'h0);
    // Both flags cleared at once, then a disable while a flag stands
    frame();
    chk({31'h0, irq}, 32'h1);
    wr(8'h1c, 32'h30);
    rd(8'h14, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    frame();
    chk({31'h0, irq}, 32'h1);
    wr(8'h18, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(8'h14, 32'h30);
    wrap_up();
  end
endmodule
bind sbrg_top sbrg_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_rx_event(i_rx_event), .i_tx_event(i_tx_event),
  .o_rate_tick(o_rate_tick), .o_port_enable(o_port_enable), .o_irq(o_irq));
